// ---- hdl/pin_ctrl_pkg.sv ----
package pin_ctrl_pkg;

  // ****************************************************************
  // Auxiliary pin function codes
  // ****************************************************************
  localparam logic [3:0] AUX_FN_ADC_WCLK   = 4'h0;
  localparam logic [3:0] AUX_FN_CLK_OUT    = 4'h1;
  localparam logic [3:0] AUX_FN_INT_SHORT  = 4'h2;
  localparam logic [3:0] AUX_FN_INT_NOISE  = 4'h3;
  localparam logic [3:0] AUX_FN_INT_BUTTON = 4'h4;
  localparam logic [3:0] AUX_FN_INT_HEAD   = 4'h5;
  localparam logic [3:0] AUX_FN_ALT_WCLK   = 4'h6;
  localparam logic [3:0] AUX_FN_DMIC       = 4'h7;
  localparam logic [3:0] AUX_FN_GP_IN      = 4'h8;
  localparam logic [3:0] AUX_FN_GP_OUT     = 4'h9;
  localparam logic [3:0] AUX_FN_ALT_DATA   = 4'ha;

  // ****************************************************************
  // Microphone oversampling selection
  // ****************************************************************
  localparam logic [1:0] OSR_SEL_128 = 2'h0;
  localparam logic [1:0] OSR_SEL_64  = 2'h1;
  localparam logic [1:0] OSR_SEL_32  = 2'h2;
  localparam int         OSR_128     = 128;
  localparam int         OSR_64      = 64;
  localparam int         OSR_32      = 32;

  // ****************************************************************
  // Interrupt pulse timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;
  localparam int PULSE_MS       = 2;
  localparam int PULSE_CYCLES   = PULSE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TRAIN_HALF_CYC = PULSE_CYCLES;

endpackage : pin_ctrl_pkg

// ---- hdl/pin_sync.sv ----
`timescale 1ns/10ps

module pin_sync
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      meta   <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule : pin_sync

// ---- hdl/int_pulse.sv ----
`timescale 1ns/10ps

module int_pulse
#(
  parameter int PULSE_CYCLES = pin_ctrl_pkg::PULSE_CYCLES
)
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic event_i,
  input  wire logic train_i,
  output logic      pulse_o
);

  localparam int CW = $clog2(PULSE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PULSE_CYCLES - 1);

  logic          event_d;
  logic [CW-1:0] count;
  logic          busy;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      event_d <= 1'b0;
    else
      event_d <= event_i;
  end

  // ****************************************************************
  // Pulse timer
  // ****************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      busy    <= 1'b0;
      count   <= '0;
      pulse_o <= 1'b0;
    end
    else if (busy)
    begin
      if (count == LAST)
      begin
        count <= '0;
        if (train_i)
        begin
          // train toggles
          // Low phase ends the train once the event is gone
          pulse_o <= !pulse_o && event_i;
          busy    <= pulse_o || event_i;
        end
        else
        begin
          busy    <= 1'b0;
          pulse_o <= 1'b0;
        end
      end
      else
        count <= count + CW'(1);
    end
    else if ((train_i && event_i) || (event_i && !event_d))
    begin
      busy    <= 1'b1;
      pulse_o <= 1'b1;
      count   <= '0;
    end
  end

endmodule : int_pulse

// ---- hdl/codec_pin_ctrl.sv ----
`timescale 1ns/10ps

module codec_pin_ctrl
#(
  parameter int PULSE_CYCLES = pin_ctrl_pkg::PULSE_CYCLES
)
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // Mode and configuration
  input  wire logic       spi_mode_i,
  input  wire logic [3:0] aux_one_func_i,
  input  wire logic [3:0] aux_two_func_i,
  input  wire logic       aux_one_train_i,
  input  wire logic       aux_two_train_i,
  input  wire logic       aux_one_level_i,
  input  wire logic       aux_two_level_i,
  input  wire logic [1:0] osr_sel_i,
  input  wire logic [1:0] ctl_data_func_i,
  input  wire logic [1:0] ctl_clk_func_i,
  input  wire logic       ctl_data_level_i,
  input  wire logic       ctl_clk_level_i,
  input  wire logic       pin_three_alt_i,
  input  wire logic       pin_two_out_en_i,
  input  wire logic       pin_two_level_i,
  // Internal sources
  input  wire logic       adc_wclk_i,
  input  wire logic       gen_clk_i,
  input  wire logic       alt_wclk_i,
  input  wire logic       short_evt_i,
  input  wire logic       noise_evt_i,
  input  wire logic       button_evt_i,
  input  wire logic       headset_evt_i,
  // Status
  output logic            aux_one_in_o,
  output logic            aux_two_in_o,
  output logic            ctl_data_in_o,
  output logic            ctl_clk_in_o,
  output logic            pin_zero_in_o,
  output logic            pin_one_in_o,
  output logic            pin_three_in_o,
  // Data toward the codec
  output logic            dmic_data_o,
  output logic            dmic_valid_o,
  output logic            alt_data_o,
  // Aux pin one
  input  wire logic       aux_pin_one_i,
  output logic            aux_pin_one_o,
  output logic            aux_pin_one_oe_o,
  // Aux pin two
  input  wire logic       aux_pin_two_i,
  output logic            aux_pin_two_o,
  output logic            aux_pin_two_oe_o,
  // Control bus pins as GPIO
  input  wire logic       ctl_data_pin_i,
  output logic            ctl_data_pin_o,
  output logic            ctl_data_pin_oe_o,
  input  wire logic       ctl_clk_pin_i,
  output logic            ctl_clk_pin_o,
  output logic            ctl_clk_pin_oe_o,
  // Shared pins
  input  wire logic       shared_pin_zero_i,
  input  wire logic       shared_pin_one_i,
  output logic            shared_pin_two_o,
  output logic            shared_pin_two_oe_o,
  input  wire logic       shared_pin_three_i
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [6:0] raw_pins;
  logic [6:0] sync_pins;
  logic       one_s;
  logic       two_s;
  logic       cd_s;
  logic       ck_s;
  logic       z_s;
  logic       o_s;
  logic       t_s;

  assign raw_pins = {shared_pin_three_i, shared_pin_one_i, shared_pin_zero_i,
                     ctl_clk_pin_i, ctl_data_pin_i, aux_pin_two_i, aux_pin_one_i};

  pin_sync #(.WIDTH(7)) u_sync
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (raw_pins),
    .sync_o  (sync_pins)
  );

  assign {t_s, o_s, z_s, ck_s, cd_s, two_s, one_s} = sync_pins;

  // ****************************************************************
  // Interrupt sources and pulse shaping
  // ****************************************************************
  logic one_evt;
  logic two_evt;
  logic one_pulse;
  logic two_pulse;

  function automatic logic pick_event(input logic [3:0] fn, input logic s,
                                      input logic n, input logic b, input logic h);
    unique case (fn)
      pin_ctrl_pkg::AUX_FN_INT_SHORT:  pick_event = s;
      pin_ctrl_pkg::AUX_FN_INT_NOISE:  pick_event = n;
      pin_ctrl_pkg::AUX_FN_INT_BUTTON: pick_event = b;
      pin_ctrl_pkg::AUX_FN_INT_HEAD:   pick_event = h;
      default:                         pick_event = 1'b0;
    endcase
  endfunction : pick_event

  assign one_evt = pick_event(aux_one_func_i, short_evt_i, noise_evt_i, button_evt_i, headset_evt_i);
  assign two_evt = pick_event(aux_two_func_i, short_evt_i, noise_evt_i, button_evt_i, headset_evt_i);

  int_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse_one
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .event_i (one_evt),
    .train_i (aux_one_train_i),
    .pulse_o (one_pulse)
  );

  int_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse_two
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .event_i (two_evt),
    .train_i (aux_two_train_i),
    .pulse_o (two_pulse)
  );

  // ****************************************************************
  // Microphone modulator clock
  // ****************************************************************
  logic [6:0] osr_count;
  logic [6:0] osr_last;
  logic       mod_clk;
  logic       mod_rise;

  always_comb
  begin
    unique case (osr_sel_i)
      pin_ctrl_pkg::OSR_SEL_64: osr_last = 7'(pin_ctrl_pkg::OSR_64 / 2 - 1);
      pin_ctrl_pkg::OSR_SEL_32: osr_last = 7'(pin_ctrl_pkg::OSR_32 / 2 - 1);
      default:                  osr_last = 7'(pin_ctrl_pkg::OSR_128 / 2 - 1);
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      osr_count <= 7'h00;
      mod_clk   <= 1'b0;
    end
    else if (osr_count >= osr_last)
    begin
      osr_count <= 7'h00;
      mod_clk   <= ~mod_clk;
    end
    else
      osr_count <= osr_count + 7'h01;
  end

  assign mod_rise = (osr_count >= osr_last) && !mod_clk;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      dmic_data_o  <= 1'b0;
      dmic_valid_o <= 1'b0;
    end
    else
    begin
      dmic_valid_o <= mod_rise && (aux_two_func_i == pin_ctrl_pkg::AUX_FN_DMIC);
      if (mod_rise)
        dmic_data_o <= two_s;
    end
  end

  // ****************************************************************
  // Auxiliary pin drive
  // ****************************************************************
  logic next_one;
  logic next_one_oe;
  logic next_two;
  logic next_two_oe;

  always_comb
  begin
    next_one    = 1'b0;
    next_one_oe = 1'b1;
    unique case (aux_one_func_i)
      pin_ctrl_pkg::AUX_FN_ADC_WCLK:  next_one = adc_wclk_i;
      pin_ctrl_pkg::AUX_FN_CLK_OUT:   next_one = gen_clk_i;
      pin_ctrl_pkg::AUX_FN_ALT_WCLK:  next_one = alt_wclk_i;
      pin_ctrl_pkg::AUX_FN_DMIC:      next_one = mod_clk;
      pin_ctrl_pkg::AUX_FN_GP_OUT:    next_one = aux_one_level_i;
      pin_ctrl_pkg::AUX_FN_INT_SHORT,
      pin_ctrl_pkg::AUX_FN_INT_NOISE,
      pin_ctrl_pkg::AUX_FN_INT_BUTTON,
      pin_ctrl_pkg::AUX_FN_INT_HEAD:  next_one = one_pulse;
      default:                        next_one_oe = 1'b0;
    endcase
  end

  always_comb
  begin
    next_two    = 1'b0;
    next_two_oe = 1'b1;
    unique case (aux_two_func_i)
      pin_ctrl_pkg::AUX_FN_GP_OUT:    next_two = aux_two_level_i;
      pin_ctrl_pkg::AUX_FN_INT_SHORT,
      pin_ctrl_pkg::AUX_FN_INT_NOISE,
      pin_ctrl_pkg::AUX_FN_INT_BUTTON,
      pin_ctrl_pkg::AUX_FN_INT_HEAD:  next_two = two_pulse;
      default:                        next_two_oe = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      aux_pin_one_o    <= 1'b0;
      aux_pin_one_oe_o <= 1'b0;
      aux_pin_two_o    <= 1'b0;
      aux_pin_two_oe_o <= 1'b0;
    end
    else
    begin
      aux_pin_one_o    <= next_one;
      aux_pin_one_oe_o <= next_one_oe;
      aux_pin_two_o    <= next_two;
      aux_pin_two_oe_o <= next_two_oe;
    end
  end

  // ****************************************************************
  // Control and shared pins
  // ****************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ctl_data_pin_o      <= 1'b0;
      ctl_data_pin_oe_o   <= 1'b0;
      ctl_clk_pin_o       <= 1'b0;
      ctl_clk_pin_oe_o    <= 1'b0;
      shared_pin_two_o    <= 1'b0;
      shared_pin_two_oe_o <= 1'b0;
    end
    else
    begin
      ctl_data_pin_o      <= ctl_data_level_i;
      ctl_data_pin_oe_o   <= spi_mode_i && ctl_data_func_i[0];
      ctl_clk_pin_o       <= ctl_clk_level_i;
      ctl_clk_pin_oe_o    <= spi_mode_i && ctl_clk_func_i[0];
      shared_pin_two_o    <= pin_two_level_i;
      shared_pin_two_oe_o <= !spi_mode_i && pin_two_out_en_i;
    end
  end

  // ****************************************************************
  // Status and input data
  // ****************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      aux_one_in_o   <= 1'b0;
      aux_two_in_o   <= 1'b0;
      ctl_data_in_o  <= 1'b0;
      ctl_clk_in_o   <= 1'b0;
      pin_zero_in_o  <= 1'b0;
      pin_one_in_o   <= 1'b0;
      pin_three_in_o <= 1'b0;
      alt_data_o     <= 1'b0;
    end
    else
    begin
      aux_one_in_o   <= (aux_one_func_i == pin_ctrl_pkg::AUX_FN_GP_IN) ? one_s : 1'b0;
      aux_two_in_o   <= (aux_two_func_i == pin_ctrl_pkg::AUX_FN_GP_IN) ? two_s : 1'b0;
      ctl_data_in_o  <= (spi_mode_i && !ctl_data_func_i[0]) ? cd_s : 1'b0;
      ctl_clk_in_o   <= (spi_mode_i && !ctl_clk_func_i[0]) ? ck_s : 1'b0;
      pin_zero_in_o  <= spi_mode_i ? 1'b0 : z_s;
      pin_one_in_o   <= spi_mode_i ? 1'b0 : o_s;
      pin_three_in_o <= (!spi_mode_i && !pin_three_alt_i) ? t_s : 1'b0;
      alt_data_o     <= (!spi_mode_i && pin_three_alt_i) ? t_s : 1'b0;
    end
  end

endmodule : codec_pin_ctrl

// ---- testbench/dmic_model.sv ----
`timescale 1ns/10ps

// ****
// Digital microphone on the aux pins
// ****
module dmic_model
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // Pins
  input  wire logic en_i,
  input  wire logic mod_clk_i,
  output logic      dat_o
);
  logic       clk_q;
  logic [7:0] pat;

  always_ff @(posedge mclk_i)
  begin
    clk_q <= mod_clk_i;
    if (!rst_n_i)
      pat <= 8'h4d;
    else if (clk_q && !mod_clk_i)
      pat <= {pat[6:0], pat[7] ^ pat[5]};
  end

  // Released line shows inverse of last bit
  assign dat_o = en_i ? pat[0] : ~pat[0];
endmodule : dmic_model

// ---- testbench/codec_pin_ctrl_chk.sv ----
`timescale 1ns/10ps

// ****
// Pin control checker
// ****
module codec_pin_ctrl_chk
#(
  parameter int PULSE_CYCLES = pin_ctrl_pkg::PULSE_CYCLES
)
(
  // Clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  // Configuration and sources
  input wire logic       spi_mode_i,
  input wire logic [3:0] aux_one_func_i,
  input wire logic       aux_one_train_i,
  input wire logic       aux_one_level_i,
  input wire logic       pin_three_alt_i,
  input wire logic       pin_two_out_en_i,
  input wire logic       pin_two_level_i,
  input wire logic       adc_wclk_i,
  input wire logic       short_evt_i,
  // Pins and status
  input wire logic       aux_pin_one_i,
  input wire logic       shared_pin_three_i,
  input wire logic       aux_pin_one_o,
  input wire logic       aux_pin_one_oe_o,
  input wire logic       shared_pin_two_o,
  input wire logic       shared_pin_two_oe_o,
  input wire logic       ctl_data_pin_oe_o,
  input wire logic       ctl_clk_pin_oe_o,
  input wire logic       aux_one_in_o,
  input wire logic       alt_data_o,
  input wire logic       dmic_valid_o
);
  default clocking
    @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  int unsigned hi_cnt;
  logic        int_q;

  // High phase length while in short interrupt mode
  always_ff @(posedge mclk_i)
    int_q <= (aux_one_func_i == pin_ctrl_pkg::AUX_FN_INT_SHORT);
  always_ff @(posedge mclk_i)
    if (!rst_n_i || !int_q || !aux_pin_one_o)
      hi_cnt <= 0;
    else
      hi_cnt <= hi_cnt + 1;

  sequence s_idle_short;
    (rst_n_i && !aux_pin_one_o && !aux_one_train_i
     && aux_one_func_i == pin_ctrl_pkg::AUX_FN_INT_SHORT)[*3];
  endsequence
  sequence s_short_rise;
    s_idle_short ##0 $rose(short_evt_i);
  endsequence

  a_pulse_start: assert property (s_short_rise |-> ##2 aux_pin_one_o)
    else $error("interrupt pulse did not start");
  a_pulse_len: assert property (aux_pin_one_o |-> hi_cnt < PULSE_CYCLES)
    else $error("interrupt pulse too long");
  a_gp_out: assert property (aux_one_func_i == pin_ctrl_pkg::AUX_FN_GP_OUT
    |=> aux_pin_one_oe_o && aux_pin_one_o == $past(aux_one_level_i)) else $error("output level wrong");
  a_wclk_route: assert property (aux_one_func_i == pin_ctrl_pkg::AUX_FN_ADC_WCLK
    |=> aux_pin_one_oe_o && aux_pin_one_o == $past(adc_wclk_i)) else $error("word clock not routed");
  a_gp_in_level: assert property ((rst_n_i && aux_one_func_i == pin_ctrl_pkg::AUX_FN_GP_IN)[*4]
    |-> aux_one_in_o == $past(aux_pin_one_i, 3)) else $error("input status wrong");
  a_spi_shared_off: assert property (spi_mode_i |=> !shared_pin_two_oe_o)
    else $error("shared pin driven in serial mode");
  a_i2c_ctl_off: assert property (!spi_mode_i |=> !ctl_data_pin_oe_o && !ctl_clk_pin_oe_o)
    else $error("control pin driven");
  a_pin_two_out: assert property (!spi_mode_i && pin_two_out_en_i
    |=> shared_pin_two_oe_o && shared_pin_two_o == $past(pin_two_level_i)) else $error("pin two wrong");
  a_alt_data: assert property ((rst_n_i && !spi_mode_i && pin_three_alt_i)[*4]
    |-> alt_data_o == $past(shared_pin_three_i, 3)) else $error("alt data wrong");
  a_valid_once: assert property (dmic_valid_o |=> !dmic_valid_o)
    else $error("mic valid too long");
endmodule : codec_pin_ctrl_chk

bind codec_pin_ctrl codec_pin_ctrl_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk_u (.*);

// ---- testbench/tb_codec_pin_ctrl.sv ----
`timescale 1ns/10ps

module tb_codec_pin_ctrl;
  localparam int PULSE = 8;
  logic       mclk_i, rst_n_i, spi_mode_i, aux_one_train_i, aux_two_train_i, mic_en, mic_dat, last;
  logic [3:0] aux_one_func_i, aux_two_func_i, evt;
  logic [1:0] osr_sel_i, ctl_data_func_i, ctl_clk_func_i;
  logic       aux_one_level_i, aux_two_level_i, ctl_data_level_i, ctl_clk_level_i, pin_two_level_i;
  logic       pin_three_alt_i, pin_two_out_en_i, adc_wclk_i, gen_clk_i, alt_wclk_i;
  logic       aux_one_in_o, aux_two_in_o, ctl_data_in_o, ctl_clk_in_o, pin_zero_in_o, pin_one_in_o, pin_three_in_o;
  logic       dmic_data_o, dmic_valid_o, alt_data_o, aux_pin_one_o, aux_pin_one_oe_o, aux_pin_two_o;
  logic       aux_pin_two_oe_o, ctl_data_pin_o, ctl_data_pin_oe_o, ctl_clk_pin_o, ctl_clk_pin_oe_o;
  logic       shared_pin_two_o, shared_pin_two_oe_o, aux_pin_one_i, aux_pin_two_i, ctl_data_pin_i, ctl_clk_pin_i;
  logic [6:0] lv;
  logic [3:0] fn[3] = '{pin_ctrl_pkg::AUX_FN_ADC_WCLK, pin_ctrl_pkg::AUX_FN_CLK_OUT, pin_ctrl_pkg::AUX_FN_ALT_WCLK};
  int         osr[3] = '{pin_ctrl_pkg::OSR_128, pin_ctrl_pkg::OSR_64, pin_ctrl_pkg::OSR_32};
  int         fail_count, check_count, n, hi, hi2, rises, vcnt;

  assign aux_pin_one_i  = aux_pin_one_oe_o ? aux_pin_one_o : lv[0];
  assign aux_pin_two_i  = aux_pin_two_oe_o ? aux_pin_two_o : (mic_en ? mic_dat : lv[1]);
  assign ctl_data_pin_i = ctl_data_pin_oe_o ? ctl_data_pin_o : lv[2];
  assign ctl_clk_pin_i  = ctl_clk_pin_oe_o ? ctl_clk_pin_o : lv[3];

  codec_pin_ctrl #(.PULSE_CYCLES(PULSE)) dut_u (.*, .short_evt_i(evt[0]), .noise_evt_i(evt[1]),
    .button_evt_i(evt[2]), .headset_evt_i(evt[3]), .shared_pin_zero_i(lv[4]),
    .shared_pin_one_i(lv[5]), .shared_pin_three_i(lv[6]));
  dmic_model mic_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .en_i(mic_en), .mod_clk_i(aux_pin_one_o), .dat_o(mic_dat));

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run;
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic step(input int c);
    repeat (c) @(negedge mclk_i);
  endtask : step

  task automatic watch(input int c);
    repeat (c)
    begin
      @(negedge mclk_i);
      hi += aux_pin_one_o;
      hi2 += aux_pin_two_o;
      rises += aux_pin_one_o & !last;
      last = aux_pin_one_o;
    end
  endtask : watch

  // Cycles up to the next mod clock rise; mic bits checked on the way
  task automatic wait_rise;
    n = 0;
    vcnt = 0;
    do
    begin
      last = aux_pin_one_o;
      @(negedge mclk_i);
      n++;
      vcnt += dmic_valid_o;
      if (dmic_valid_o)
        chk(32'(dmic_data_o), 32'(mic_dat));
      if (n > 400)
      begin
        fail_count++;
        complete_run;
      end
    end
    while (!(aux_pin_one_o && !last));
  endtask : wait_rise

  initial
  begin
    {fail_count, check_count, hi, hi2, rises} = '0;
    {rst_n_i, spi_mode_i, aux_one_train_i, aux_two_train_i, mic_en, last, evt, lv} = '0;
    {aux_one_func_i, aux_two_func_i, osr_sel_i, ctl_data_func_i, ctl_clk_func_i} = '0;
    {aux_one_level_i, aux_two_level_i, ctl_data_level_i, ctl_clk_level_i, pin_two_level_i} = '0;
    {pin_three_alt_i, pin_two_out_en_i, adc_wclk_i, gen_clk_i, alt_wclk_i} = '0;
    step(3);
    chk(32'({aux_pin_one_oe_o, aux_pin_two_oe_o, ctl_data_pin_oe_o, ctl_clk_pin_oe_o, shared_pin_two_oe_o}), 32'h0);
    rst_n_i = 1'b1;
    for (int k = 0; k < 3; k++)
      for (int v = 0; v < 2; v++)
      begin
        aux_one_func_i = fn[k];
        {alt_wclk_i, gen_clk_i, adc_wclk_i} = v ? 3'h1 << k : ~(3'h1 << k);
        step(3);
        chk(32'({aux_pin_one_oe_o, aux_pin_one_o}), 32'({1'b1, v[0]}));
      end
    for (int s = 0; s < 2; s++)
      for (int v = 0; v < 2; v++)
      begin
        spi_mode_i = s[0];
        {aux_one_func_i, aux_two_func_i} = {2{pin_ctrl_pkg::AUX_FN_GP_IN}};
        {ctl_data_func_i, ctl_clk_func_i, pin_three_alt_i, pin_two_out_en_i} = '0;
        lv = v ? 7'h55 : 7'h2a;
        step(4);
        chk(32'({shared_pin_two_oe_o, pin_three_in_o, pin_one_in_o, pin_zero_in_o, ctl_clk_in_o, ctl_data_in_o,
             aux_two_in_o, aux_one_in_o}), 32'(lv & (s ? 7'h0f : 7'h73)));
        {aux_one_func_i, aux_two_func_i} = {2{pin_ctrl_pkg::AUX_FN_GP_OUT}};
        {ctl_data_func_i, ctl_clk_func_i, pin_two_out_en_i, pin_three_alt_i} = {2'h1, 2'h1, 1'b1, 1'b1};
        {aux_one_level_i, aux_two_level_i, ctl_data_level_i, ctl_clk_level_i} = {v[0], !v[0], v[0], !v[0]};
        pin_two_level_i = v[0];
        step(4);
        chk(32'({aux_pin_one_oe_o, aux_pin_one_o, aux_pin_two_oe_o, aux_pin_two_o}),
            32'({1'b1, v[0], 1'b1, !v[0]}));
        chk(32'({ctl_data_pin_oe_o, ctl_data_pin_oe_o & ctl_data_pin_o, ctl_clk_pin_oe_o,
                 ctl_clk_pin_oe_o & ctl_clk_pin_o, shared_pin_two_oe_o, shared_pin_two_oe_o & shared_pin_two_o}),
            32'({s[0], s[0] & v[0], s[0], s[0] & !v[0], !s[0], !s[0] & v[0]}));
        chk(32'(alt_data_o), 32'(!s[0] & lv[6]));
      end
    for (int k = 0; k < 4; k++)
    begin
      {aux_one_func_i, aux_two_func_i} = {2{fn[0] + 4'(k + 2)}};
      {hi, hi2, evt} = '0;
      step(3);
      evt = ~(4'h1 << k);
      watch(3);
      evt = 4'hf;
      watch(2);
      evt = ~(4'h1 << k);
      watch(2);
      evt = 4'hf;
      watch(20);
      evt = 4'h0;
      chk(32'({hi[7:0], hi2[7:0]}), 32'({2{8'(PULSE)}}));
      step(12);
    end
    {aux_one_train_i, aux_two_train_i, hi, hi2, rises} = '1;
    {hi, hi2, rises} = '0;
    evt = 4'h8;
    watch(36);
    evt = 4'h0;
    watch(30);
    chk(32'({rises[7:0], hi[7:0], hi2[7:0]}), 32'({8'h03, 8'(3 * PULSE), 8'(3 * PULSE)}));
    {aux_one_func_i, aux_two_func_i} = {2{pin_ctrl_pkg::AUX_FN_DMIC}};
    mic_en = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      osr_sel_i = 2'(k);
      step(300);
      wait_rise;
      wait_rise;
      chk(32'({n[7:0], vcnt[7:0], aux_pin_one_oe_o, aux_pin_two_oe_o}), 32'({8'(osr[k]), 8'h01, 2'h2}));
    end
    complete_run;
  end
endmodule : tb_codec_pin_ctrl
